// ---- ram_coef_filter_map.svh ----
// offsets, field positions, reset values and scaling constants of the filter
`ifndef RAM_COEF_FILTER_MAP_SVH
`define RAM_COEF_FILTER_MAP_SVH
// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define IDX_COEF_LAST 8'h7F
`define IDX_DECIM 8'hA0
`define IDX_PHASE 8'hA1
`define IDX_TAPS 8'hA2
`define IDX_COFS 8'hA3
`define IDX_CTRL 8'hA4
// ************************************************************
// control register fields
// ************************************************************
`define CTRL_SCALE_MSB 3
`define CTRL_FMT_MSB 5
`define CTRL_FMT_LSB 4
`define CTRL_FIX_EXP 6
`define CTRL_SHARED_EXP 7
`define CTRL_PAGE 8
`define CTRL_ALT_SRC 9
`define CTRL_BYPASS 10
// ************************************************************
// reset values
// ************************************************************
`define RST_BYTE 8'h00
`define RST_CTRL 11'h000
// ************************************************************
// widths and scaling constants
// ************************************************************
`define SAMPLE_W 20
`define RESULT_W 24
`define ACC_ALIGN 5'h12
`define EXP_HEADROOM 6'h06
`define EXP_MAX 6'h0F
`endif

// ---- ram_coef_filter_pkg.sv ----
// types shared by the coefficient filter
`include "ram_coef_filter_map.svh"
package ram_coef_filter_pkg;
  // one complex input sample
  typedef struct packed {
    logic [`SAMPLE_W-1:0] i;
    logic [`SAMPLE_W-1:0] q;
  } sample_type;
  // one complex output word
  typedef struct packed {
    logic [`RESULT_W-1:0] i;
    logic [`RESULT_W-1:0] q;
  } result_type;
  // sum-of-products sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } fsm_type;
endpackage : ram_coef_filter_pkg

// ---- ram_coefficient_decimating_filter.sv ----
// decimating sum-of-products filter with coefficient memory and AHB-Lite registers
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "ram_coef_filter_map.svh"
module ram_coefficient_decimating_filter
  import ram_coef_filter_pkg::*;
#(
  parameter int DEPTH = 160,
  parameter int COEF_WORDS = 256
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // comb stage inputs
  input wire sample_type own_sample_i,
  input wire logic own_valid_i,
  input wire sample_type alt_sample_i,
  input wire logic alt_valid_i,
  // filter results
  output result_type result_o,
  output logic result_valid_o
);
  // ************************************************************
  // registers and memories
  // ************************************************************
  logic [7:0] decimation_factor_minus_one; // decimation factor less one
  logic [7:0] decimation_phase_preload; // counter preload
  logic [7:0] tap_count_minus_one; // taps less one
  logic [7:0] coefficient_start_offset; // first coefficient
  logic [10:0] output_scale_and_control; // compound control
  logic [`SAMPLE_W-1:0] coefficient_memory [COEF_WORDS]; // two pages
  sample_type sample_memory [DEPTH]; // circular sample store
  // ************************************************************
  // helpers
  // ************************************************************
  // count of redundant sign bits below the sign
  function automatic logic [5:0] sign_run(input logic signed [47:0] v);
    logic [5:0] n;
    logic stop;
    n = 6'h00;
    stop = 1'b0;
    for (int b = 46; b >= 0; b--) begin
      if (!stop && v[b] == v[47]) n = n + 6'h01;
      else stop = 1'b1;
    end
    return n;
  endfunction : sign_run
  // scale by 2^(e-18) into 24 bits with saturation
  function automatic logic [23:0] scale_sat(input logic signed [47:0] acc,
                                            input logic [3:0] e);
    logic signed [47:0] s;
    s = acc >>> (`ACC_ALIGN - {1'b0, e});
    if (s > 48'sh0000007FFFFF) return 24'h7FFFFF;
    else if (s < -48'sh000000800000) return 24'h800000;
    else return s[23:0];
  endfunction : scale_sat
  // largest exponent that cannot overflow
  function automatic logic [3:0] auto_exp(input logic signed [47:0] acc);
    logic [5:0] r;
    logic [5:0] d;
    r = sign_run(acc);
    d = r - `EXP_HEADROOM;
    if (r <= `EXP_HEADROOM) return 4'h0;
    else if (d > `EXP_MAX) return 4'hF;
    else return d[3:0];
  endfunction : auto_exp
  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  logic dp_write; // write data phase pending
  logic dp_read; // read data phase pending
  logic [7:0] dp_idx; // register index of data phase
  logic dp_map; // index inside the map
  logic accept; // address phase taken
  logic [31:0] read_word; // decoded read value
  assign accept = hsel_i && hready_i && htrans_i[1];
  // capture the address phase; reads take one wait state
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_idx <= 8'h00;
      dp_map <= 1'b0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h00000000;
    end else begin
      hresp_o <= 1'b0; // always okay
      dp_write <= accept && hwrite_i;
      dp_read <= accept && !hwrite_i;
      if (accept) begin
        dp_idx <= haddr_i[9:2];
        dp_map <= (haddr_i[31:10] == 22'h000000);
      end
      if (accept && !hwrite_i) begin
        hreadyout_o <= 1'b0; // insert wait
      end else if (dp_read) begin
        hreadyout_o <= 1'b1;
        hrdata_o <= read_word;
      end
    end
  end
  // read decode, unmapped reads return zero
  always_comb begin
    read_word = 32'h00000000;
    if (dp_map) begin
      if (dp_idx <= `IDX_COEF_LAST) begin
        read_word = {12'h000, coefficient_memory[{output_scale_and_control[`CTRL_PAGE],
                                                  dp_idx[6:0]}]};
      end else begin
        case (dp_idx)
          `IDX_DECIM: read_word = {24'h000000, decimation_factor_minus_one};
          `IDX_PHASE: read_word = {24'h000000, decimation_phase_preload};
          `IDX_TAPS: read_word = {24'h000000, tap_count_minus_one};
          `IDX_COFS: read_word = {24'h000000, coefficient_start_offset};
          `IDX_CTRL: read_word = {21'h000000, output_scale_and_control};
          default: read_word = 32'h00000000;
        endcase
      end
    end
  end
  logic wr_coef; // coefficient write this cycle
  assign wr_coef = dp_write && dp_map && (dp_idx <= `IDX_COEF_LAST);
  // control register writes
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      decimation_factor_minus_one <= `RST_BYTE;
      decimation_phase_preload <= `RST_BYTE;
      tap_count_minus_one <= `RST_BYTE;
      coefficient_start_offset <= `RST_BYTE;
      output_scale_and_control <= `RST_CTRL;
    end else if (dp_write && dp_map) begin
      case (dp_idx)
        `IDX_DECIM: decimation_factor_minus_one <= hwdata_i[7:0];
        `IDX_PHASE: decimation_phase_preload <= hwdata_i[7:0];
        `IDX_TAPS: tap_count_minus_one <= hwdata_i[7:0];
        `IDX_COFS: coefficient_start_offset <= hwdata_i[7:0];
        `IDX_CTRL: output_scale_and_control <= hwdata_i[10:0];
        default: ;
      endcase
    end
  end
  // coefficient memory, page bit above word index
  always_ff @(posedge ref_clk_i) begin
    if (wr_coef) begin
      coefficient_memory[{output_scale_and_control[`CTRL_PAGE], dp_idx[6:0]}]
        <= hwdata_i[`SAMPLE_W-1:0];
    end
  end
  // ************************************************************
  // sample input and decimation
  // ************************************************************
  logic bypass; // self-test bypass
  sample_type in_sample; // selected source
  logic in_valid; // selected strobe
  logic [7:0] phase_cnt; // decimation counter
  logic [7:0] wr_ptr; // next slot to fill
  logic trigger; // start an output
  assign bypass = output_scale_and_control[`CTRL_BYPASS];
  // own or alternate comb source
  assign in_sample = output_scale_and_control[`CTRL_ALT_SRC] ? alt_sample_i
                                                               : own_sample_i;
  assign in_valid = output_scale_and_control[`CTRL_ALT_SRC] ? alt_valid_i : own_valid_i;
  assign trigger = in_valid && !bypass && (phase_cnt == decimation_factor_minus_one);
  // circular sample store; contents are not cleared at reset or by the host
  always_ff @(posedge ref_clk_i) begin
    if (in_valid) sample_memory[wr_ptr] <= in_sample;
  end
  // write pointer wraps at the buffer depth
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wr_ptr <= 8'h00;
    end else if (in_valid) begin
      wr_ptr <= (wr_ptr == 8'(DEPTH - 1)) ? 8'h00 : wr_ptr + 8'h01;
    end
  end
  // phase counter, preloaded when the phase is written
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      phase_cnt <= `RST_BYTE;
    end else if (dp_write && dp_map && dp_idx == `IDX_PHASE) begin
      phase_cnt <= hwdata_i[7:0];
    end else if (in_valid && !bypass) begin
      phase_cnt <= trigger ? 8'h00 : phase_cnt + 8'h01;
    end
  end
  // ************************************************************
  // sum-of-products sequencer
  // ************************************************************
  fsm_type state; // sequencer state
  logic [7:0] taps_eff; // taps less one, clamped to depth less one
  logic [8:0] start_sum; // newest minus taps plus depth
  logic [7:0] start_ptr; // oldest sample of the window
  logic [7:0] rd_ptr; // sample being used
  logic [7:0] coef_ptr; // coefficient being used
  logic [7:0] taps_left; // taps after this one
  logic signed [47:0] acc_i; // I accumulator
  logic signed [47:0] acc_q; // Q accumulator
  logic signed [39:0] prod_i; // I product
  logic signed [39:0] prod_q; // Q product
  logic [`SAMPLE_W-1:0] coef; // shared coefficient
  sample_type tap_sample; // sample of this tap
  assign taps_eff = (tap_count_minus_one > 8'(DEPTH - 1)) ? 8'(DEPTH - 1)
                                                          : tap_count_minus_one;
  // newest sample is the one written with the trigger
  assign start_sum = {1'b0, wr_ptr} + 9'(DEPTH) - {1'b0, taps_eff};
  assign start_ptr = (start_sum >= 9'(DEPTH)) ? 8'(start_sum - 9'(DEPTH))
                                              : start_sum[7:0];
  assign coef = coefficient_memory[coef_ptr];
  assign tap_sample = sample_memory[rd_ptr];
  assign prod_i = $signed(coef) * $signed(tap_sample.i);
  assign prod_q = $signed(coef) * $signed(tap_sample.q);
  // walk oldest to newest with rising coefficient address
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      rd_ptr <= 8'h00;
      coef_ptr <= 8'h00;
      taps_left <= 8'h00;
      acc_i <= 48'sh0;
      acc_q <= 48'sh0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (trigger) begin
            state <= ST_RUN;
            rd_ptr <= start_ptr;
            coef_ptr <= coefficient_start_offset;
            taps_left <= taps_eff;
            acc_i <= 48'sh0;
            acc_q <= 48'sh0;
          end
        end
        ST_RUN: begin
          acc_i <= acc_i + {{8{prod_i[39]}}, prod_i};
          acc_q <= acc_q + {{8{prod_q[39]}}, prod_q};
          rd_ptr <= (rd_ptr == 8'(DEPTH - 1)) ? 8'h00 : rd_ptr + 8'h01;
          coef_ptr <= coef_ptr + 8'h01;
          taps_left <= taps_left - 8'h01;
          if (taps_left == 8'h00) state <= ST_DONE;
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end
  // ************************************************************
  // output formatting
  // ************************************************************
  logic [3:0] scale; // programmed scale value
  logic [1:0] fmt; // output format
  logic [3:0] exp_i; // I exponent
  logic [3:0] exp_q; // Q exponent
  logic [23:0] fix_i; // I at chosen scale
  logic [23:0] fix_q; // Q at chosen scale
  result_type next_result; // formatted word
  assign scale = output_scale_and_control[`CTRL_SCALE_MSB:0];
  assign fmt = output_scale_and_control[`CTRL_FMT_MSB:`CTRL_FMT_LSB];
  // exponent choice, then scaled and saturated values
  always_comb begin
    exp_i = auto_exp(acc_i);
    exp_q = auto_exp(acc_q);
    if (fmt == 2'b00 || output_scale_and_control[`CTRL_FIX_EXP]) begin
      exp_i = scale;
      exp_q = scale;
    end else if (output_scale_and_control[`CTRL_SHARED_EXP]) begin
      exp_i = (exp_i < exp_q) ? exp_i : exp_q;
      exp_q = exp_i;
    end
    fix_i = scale_sat(acc_i, exp_i);
    fix_q = scale_sat(acc_q, exp_q);
    case (fmt)
      2'b00: next_result = '{i: fix_i, q: fix_q};
      2'b01: next_result = '{i: {12'h000, fix_i[23:16], exp_i},
                             q: {12'h000, fix_q[23:16], exp_q}};
      default: next_result = '{i: {8'h00, fix_i[23:12], exp_i},
                               q: {8'h00, fix_q[23:12], exp_q}};
    endcase
  end
  // result register; bypass passes samples through, shifted up four bits
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      result_o <= '0;
      result_valid_o <= 1'b0;
    end else if (bypass) begin
      result_valid_o <= in_valid;
      if (in_valid) result_o <= '{i: {in_sample.i, 4'h0}, q: {in_sample.q, 4'h0}};
    end else begin
      result_valid_o <= (state == ST_DONE);
      if (state == ST_DONE) result_o <= next_result;
    end
  end
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence read_taken;
    accept && !hwrite_i;
  endsequence
  sequence read_answer;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  AST_BUS_READ_WAIT: assert property (read_taken |=> read_answer)
    else $error("read answer not after one wait state");
  AST_BUS_OKAY: assert property (hresp_o == 1'b0)
    else $error("slave answered other than okay");
  AST_COEF_PAGE: assert property (wr_coef |=>
    coefficient_memory[{$past(output_scale_and_control[`CTRL_PAGE]), $past(dp_idx[6:0])}]
      == $past(hwdata_i[`SAMPLE_W-1:0]))
    else $error("coefficient not stored at page and index");
  AST_PHASE_PRELOAD: assert property (dp_write && dp_map && dp_idx == `IDX_PHASE |=>
    phase_cnt == $past(hwdata_i[7:0]))
    else $error("phase counter not preloaded");
  AST_DECIM_WRAP: assert property (trigger && !(dp_write && dp_idx == `IDX_PHASE) |=>
    phase_cnt == 8'h00)
    else $error("decimation counter did not restart");
  AST_WINDOW_START: assert property (state == ST_IDLE && trigger |=>
    state == ST_RUN && rd_ptr == $past(start_ptr) && taps_left == $past(taps_eff)
    && coef_ptr == $past(coefficient_start_offset))
    else $error("tap walk started at wrong place");
  sequence last_tap;
    state == ST_RUN && taps_left == 8'h00;
  endsequence
  AST_RESULT_AFTER_LAST: assert property (last_tap ##0 !bypass ##1 !bypass |=>
    state == ST_IDLE && result_valid_o)
    else $error("result missing after last tap");
  AST_PTR_RANGE: assert property (wr_ptr < 8'(DEPTH) && rd_ptr < 8'(DEPTH))
    else $error("sample pointer outside buffer");
  AST_TAPS_LIMIT: assert property (taps_eff <= 8'(DEPTH - 1))
    else $error("tap count beyond buffer depth");
  AST_BYPASS_PASS: assert property (bypass && in_valid && $stable(bypass) |=>
    result_valid_o && result_o.i == {$past(in_sample.i), 4'h0})
    else $error("bypass did not pass the sample");
endmodule : ram_coefficient_decimating_filter

// ---- comb_source_model.sv ----
// comb stage model: one-cycle sample pulses separated by idle gaps
`timescale 1ns/100ps
module comb_source_model
  import ram_coef_filter_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // sample stream
  output sample_type sample_o,
  output logic valid_o
);
  // idle at time zero
  initial begin
    sample_o = '0;
    valid_o = 1'b0;
  end
  // ************************************************************
  // one sample, then idle with inverted data so stale values never match
  // ************************************************************
  task send(input sample_type s, input int gap);
    sample_o <= s;
    valid_o <= 1'b1;
    @(posedge ref_clk_i);
    valid_o <= 1'b0;
    sample_o <= ~s;
    repeat (gap) @(posedge ref_clk_i);
  endtask : send
endmodule : comb_source_model

// ---- ram_coefficient_decimating_filter_tb.sv ----
// testbench: register access, tap order, decimation, formats, source and bypass
`timescale 1ns/100ps
module ram_coefficient_decimating_filter_tb
  import ram_coef_filter_pkg::*;
;
  logic ref_clk_i;
  logic resetn_i;
  logic hsel, hwrite, hreadyout, hresp, result_valid;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  sample_type own_s, alt_s;
  logic own_v, alt_v;
  result_type result, last;
  int n_errors = 0;
  int checked = 0;
  int n_res = 0;
  int base;
  ram_coefficient_decimating_filter DUT (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .own_sample_i(own_s), .own_valid_i(own_v), .alt_sample_i(alt_s),
    .alt_valid_i(alt_v), .result_o(result), .result_valid_o(result_valid));
  comb_source_model own_src (.ref_clk_i(ref_clk_i), .sample_o(own_s), .valid_o(own_v));
  comb_source_model alt_src (.ref_clk_i(ref_clk_i), .sample_o(alt_s), .valid_o(alt_v));
  // clock, 5 ns period
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // capture every result pulse
  always @(posedge ref_clk_i) begin
    if (result_valid === 1'b1) begin
      last <= result;
      n_res <= n_res + 1;
    end
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // one single ahb-lite transfer, waits for hready in both phases
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, {22'h0, idx, 2'b00}, d);
  endtask : wr
  task rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
    bus(1'b0, {22'h0, idx, 2'b00}, 32'h0);
    check(r, exp, what);
    check({31'h0, hresp}, 32'h0, "okay response");
  endtask : rd
  function automatic sample_type sp(input int i, input int q);
    sp = {20'(i), 20'(q)};
  endfunction : sp
  task res(input int i, input int q, input string what);
    check({8'h0, last.i}, {8'h0, 24'(i)}, what);
    check({8'h0, last.q}, {8'h0, 24'(q)}, what);
  endtask : res
  // verdict, reached from the main sequence or the watchdog
  task summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  // watchdog on a hang
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    summarize();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    resetn_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    for (int k = 0; k < 5; k++) begin
      rd(8'(8'hA0 + k), 32'h0, "reset value");
      wr(8'(8'hA0 + k), 32'hFFFFFFFF);
      rd(8'(8'hA0 + k), (k == 4) ? 32'h7FF : 32'hFF, "field width");
    end
    rd(8'hA5, 32'h0, "unmapped index");
    bus(1'b0, 32'h400, 32'h0);
    check(r, 32'h0, "unmapped high address");
    wr(8'hA4, 32'h100);
    wr(8'h00, 32'hFFF11111);
    wr(8'hA4, 32'h0);
    wr(8'h00, 32'h22222);
    rd(8'h00, 32'h22222, "page 0 word");
    wr(8'hA4, 32'h100);
    rd(8'h00, 32'h11111, "page 1 word");
    wr(8'h00, 32'h40000);
    wr(8'hA4, 32'h0);
    for (int k = 2; k < 7; k++) wr(8'(k), (k == 4) ? 32'h40000 : 32'h0);
    wr(8'h7E, 32'h0);
    wr(8'h7F, 32'h0);
    $display("test registers done");
    wr(8'hA0, 32'h0);
    wr(8'hA1, 32'h0);
    wr(8'hA2, 32'h0);
    wr(8'hA3, 32'h4);
    for (int k = 0; k < 160; k++) own_src.send(sp(0, 0), 4);
    check(32'(n_res), 32'd160, "one output per sample");
    wr(8'hA4, 32'h4);
    own_src.send(sp(100, -3), 8);
    res(1600, -48, "fixed scale 4");
    wr(8'hA4, 32'h54);
    own_src.send(sp(4096, 0), 8);
    res(24'h000014, 24'h000004, "float 8+4");
    for (int f = 0; f < 2; f++) begin
      wr(8'hA4, 32'h64 + 32'(f * 16));
      own_src.send(sp(4096, 0), 8);
      res(24'h000104, 24'h000004, "float 12+4");
    end
    wr(8'hA4, 32'h10);
    own_src.send(sp(4096, 0), 8);
    res(24'h00040A, 24'h00000F, "auto exponent");
    wr(8'hA4, 32'h90);
    own_src.send(sp(4096, 0), 8);
    res(24'h00040A, 24'h00000A, "shared exponent");
    wr(8'hA4, 32'h0);
    $display("test formats done");
    wr(8'hA2, 32'h2);
    for (int k = 1; k < 4; k++) own_src.send(sp(k * 10, -k * 10), 8);
    res(10, -10, "oldest meets offset");
    wr(8'hA3, 32'h2);
    own_src.send(sp(40, -40), 8);
    res(40, -40, "newest meets last tap");
    wr(8'hA3, 32'h7E);
    own_src.send(sp(50, 60), 8);
    res(50, 60, "pages contiguous");
    $display("test taps done");
    wr(8'hA2, 32'h0);
    wr(8'hA3, 32'h4);
    wr(8'hA0, 32'h2);
    wr(8'hA1, 32'h0);
    base = n_res;
    for (int k = 1; k < 7; k++) own_src.send(sp(k * 7, 0), 8);
    check(32'(n_res - base), 32'd2, "decimate by 3");
    res(42, 0, "decimated sample");
    wr(8'hA1, 32'h2);
    own_src.send(sp(5, 0), 8);
    check(32'(n_res - base), 32'd3, "phase preload");
    res(5, 0, "preloaded trigger");
    $display("test decimation done");
    wr(8'hA0, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(8'hA4, (k == 0) ? 32'h200 : 32'h0);
      fork
        own_src.send(sp(1, 1), 8);
        alt_src.send(sp(77, -77), 8);
      join
      if (k == 0) res(77, -77, "alternate source");
      else res(1, 1, "own source");
    end
    wr(8'hA4, 32'h400);
    own_src.send(sp(32'h12345, 32'hFEDCB), 8);
    res(24'h123450, 24'hFEDCB0, "bypass");
    wr(8'hA4, 32'h0);
    $display("test source and bypass done");
    summarize();
  end
endmodule : ram_coefficient_decimating_filter_tb
